//--- design/caf_defs.vh
`ifndef CAF_DEFS_VH
`define CAF_DEFS_VH

// ==========================================================================
// Register map
`define CAF_MODE_ADDR 32'hE0087000
`define CAF_SECT_ADDR 32'hE0087004
`define CAF_STAT_ADDR 32'hE00870F0

// ==========================================================================
// Mode register fields
`define CAF_MODE_OFF_BIT 0
`define CAF_MODE_BYP_BIT 1
`define CAF_MODE_EXT_BIT 2
`define CAF_MODE_W 3
`define CAF_MODE_RST 3'h1

// ==========================================================================
// Section start-address field
`define CAF_SECT_LSB 2
`define CAF_SECT_MSB 11
`define CAF_SECT_W 10
`define CAF_SECT_RST 10'h000

// ==========================================================================
// Status register fields
`define CAF_STAT_BUSY_BIT 0
`define CAF_STAT_MODE_LSB 1

// ==========================================================================
// AHB-Lite codes
`define CAF_HTRANS_NONSEQ 2'h2
`define CAF_HTRANS_SEQ 2'h3
`define CAF_HSIZE_WORD 3'h2
`define CAF_HRESP_OKAY 1'h0

`endif

//--- design/caf_frame_judge.v
`timescale 1ns/1ps
`include "caf_defs.vh"

module caf_frame_judge (
    clock,
    sys_rst,
    mode_in,
    rx_eval_start,
    rx_ctrl_enabled,
    lut_result_valid,
    lut_id_match,
    lut_search_req,
    rx_accept,
    rx_discard,
    rx_auto_store,
    busy,
    mode_used
);
    input wire clock;
    input wire sys_rst;
    input wire [`CAF_MODE_W-1:0] mode_in;
    input wire rx_eval_start;
    input wire rx_ctrl_enabled;
    input wire lut_result_valid;
    input wire lut_id_match;
    output reg lut_search_req;
    output reg rx_accept;
    output reg rx_discard;
    output reg rx_auto_store;
    output reg busy;
    output reg [`CAF_MODE_W-1:0] mode_used;

    // ======================================================================
    // States
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_SEARCH = 2'h2;

    reg [1:0] state_r;

    // ======================================================================
    // Per-frame decision; mode is frozen at evaluation start
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            mode_used <= `CAF_MODE_RST;
            lut_search_req <= 1'b0;
            rx_accept <= 1'b0;
            rx_discard <= 1'b0;
            rx_auto_store <= 1'b0;
            busy <= 1'b0;
        end else begin
            lut_search_req <= 1'b0;
            rx_accept <= 1'b0;
            rx_discard <= 1'b0;
            rx_auto_store <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (rx_eval_start) begin
                        mode_used <= mode_in;
                        if (mode_in[`CAF_MODE_BYP_BIT]) begin
                            rx_accept <= rx_ctrl_enabled;
                            rx_discard <= ~rx_ctrl_enabled;
                        end else if (mode_in[`CAF_MODE_OFF_BIT]) begin
                            rx_discard <= 1'b1;
                        end else begin
                            lut_search_req <= 1'b1;
                            busy <= 1'b1;
                            state_r <= ST_SEARCH;
                        end
                    end
                end
                ST_SEARCH: begin
                    // A write landing mid-search does not touch mode_used
                    if (lut_result_valid) begin
                        rx_accept <= lut_id_match & rx_ctrl_enabled;
                        rx_discard <= ~(lut_id_match & rx_ctrl_enabled);
                        rx_auto_store <= lut_id_match & rx_ctrl_enabled
                            & mode_used[`CAF_MODE_EXT_BIT];
                        busy <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    busy <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- design/caf_mode_top.v
`timescale 1ns/1ps
`include "caf_defs.vh"

module caf_mode_top (
    clock,
    sys_rst,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hrdata,
    hresp,
    rx_eval_start,
    rx_ctrl_enabled,
    lut_result_valid,
    lut_id_match,
    lut_search_req,
    rx_accept,
    rx_discard,
    rx_auto_store,
    auto_store_extension_enable,
    filter_bypass,
    filter_off,
    lut_section_start
);
    input wire clock;
    input wire sys_rst;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg hreadyout;
    output reg [31:0] hrdata;
    output reg hresp;
    input wire rx_eval_start;
    input wire rx_ctrl_enabled;
    input wire lut_result_valid;
    input wire lut_id_match;
    output wire lut_search_req;
    output wire rx_accept;
    output wire rx_discard;
    output wire rx_auto_store;
    output reg auto_store_extension_enable;
    output reg filter_bypass;
    output reg filter_off;
    output reg [`CAF_SECT_W-1:0] lut_section_start;

    // ======================================================================
    // Register selection
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_MODE = 3'h1;
    localparam [2:0] SEL_SECT = 3'h2;
    localparam [2:0] SEL_STAT = 3'h4;
    localparam [`CAF_MODE_W-1:0] MODE_RST = `CAF_MODE_RST;

    function [2:0] reg_sel;
        input [31:0] addr;
        begin
            case (addr)
                `CAF_MODE_ADDR: reg_sel = SEL_MODE;
                `CAF_SECT_ADDR: reg_sel = SEL_SECT;
                `CAF_STAT_ADDR: reg_sel = SEL_STAT;
                default: reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    wire [`CAF_MODE_W-1:0] mode_cur;
    wire judge_busy;
    wire [`CAF_MODE_W-1:0] judge_mode;
    wire addr_phase;
    wire [2:0] addr_sel;
    reg wr_pend_r;
    reg [2:0] wr_sel_r;
    reg [31:0] rd_nxt;
    wire [`CAF_MODE_W-1:0] mode_wdata;
    wire sect_open;
    wire mode_wr;
    wire sect_wr;

    assign mode_cur = {auto_store_extension_enable, filter_bypass, filter_off};
    assign addr_phase = hsel & hready & htrans[1];
    assign addr_sel = reg_sel(haddr);
    // Upper mode bits are never stored, so they always read back zero
    assign mode_wdata = hwdata[`CAF_MODE_W-1:0];
    // Section writes are open whenever bypass or off is set, even while a frame started earlier is still searching
    assign sect_open = filter_bypass | filter_off;

    // ======================================================================
    // Read mux; unused bits read as zero
    always @* begin
        rd_nxt = 32'h00000000;
        case (addr_sel)
            SEL_MODE: begin
                rd_nxt[`CAF_MODE_W-1:0] = mode_cur;
            end
            SEL_SECT: begin
                rd_nxt[`CAF_SECT_MSB:`CAF_SECT_LSB] = lut_section_start;
            end
            SEL_STAT: begin
                // Shows the mode the last frame was judged under, not the live one
                rd_nxt[`CAF_STAT_BUSY_BIT] = judge_busy;
                rd_nxt[`CAF_STAT_MODE_LSB+`CAF_MODE_W-1:`CAF_STAT_MODE_LSB] = judge_mode;
            end
            SEL_NONE: begin
                // Unmapped addresses read zero and ignore writes
                rd_nxt = 32'h00000000;
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    // ======================================================================
    // AHB-Lite response: zero wait states, always OKAY
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= `CAF_HRESP_OKAY;
        end else begin
            // The one slave never stalls, so every transfer ends after one data phase
            hreadyout <= 1'b1;
            hresp <= `CAF_HRESP_OKAY;
        end
    end

    // ======================================================================
    // Address phase capture; hsize is not checked, only whole words are defined
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
            wr_pend_r <= 1'b0;
            wr_sel_r <= SEL_NONE;
        end else if (addr_phase) begin
            wr_pend_r <= hwrite;
            wr_sel_r <= addr_sel;
            // Read data is staged at the address edge so it stands in the data phase
            hrdata <= hwrite ? 32'h00000000 : rd_nxt;
        end else begin
            wr_pend_r <= 1'b0;
            wr_sel_r <= SEL_NONE;
        end
    end

    // ======================================================================
    // Write strobes; a write lands at the edge that ends its data phase
    // Unmapped writes raise no strobe and are dropped
    assign mode_wr = wr_pend_r & (wr_sel_r == SEL_MODE);
    // Changing the table layout while screening would corrupt searches
    assign sect_wr = wr_pend_r & (wr_sel_r == SEL_SECT) & sect_open;

    // ======================================================================
    // Off bit; set out of reset so nothing is received before setup
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            filter_off <= MODE_RST[`CAF_MODE_OFF_BIT];
        end else if (mode_wr) begin
            // Ignored by the judge while bypass is set
            filter_off <= mode_wdata[`CAF_MODE_OFF_BIT];
        end
    end

    // ======================================================================
    // Bypass bit
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            filter_bypass <= MODE_RST[`CAF_MODE_BYP_BIT];
        end else if (mode_wr) begin
            // Wins over the off bit in the judge
            filter_bypass <= mode_wdata[`CAF_MODE_BYP_BIT];
        end
    end

    // ======================================================================
    // Extension bit
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            auto_store_extension_enable <= MODE_RST[`CAF_MODE_EXT_BIT];
        end else if (mode_wr) begin
            // Frames already being judged keep the value they started with
            auto_store_extension_enable <= mode_wdata[`CAF_MODE_EXT_BIT];
        end
    end

    // ======================================================================
    // Section start address
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lut_section_start <= `CAF_SECT_RST;
        end else if (sect_wr) begin
            // A refused write still ends on the bus with OKAY
            lut_section_start <= hwdata[`CAF_SECT_MSB:`CAF_SECT_LSB];
        end
    end

    // ======================================================================
    // Per-frame judge
    caf_frame_judge u_judge (
        .clock(clock),
        .sys_rst(sys_rst),
        .mode_in(mode_cur),
        .rx_eval_start(rx_eval_start),
        .rx_ctrl_enabled(rx_ctrl_enabled),
        .lut_result_valid(lut_result_valid),
        .lut_id_match(lut_id_match),
        .lut_search_req(lut_search_req),
        .rx_accept(rx_accept),
        .rx_discard(rx_discard),
        .rx_auto_store(rx_auto_store),
        .busy(judge_busy),
        .mode_used(judge_mode)
    );

endmodule

//--- sim/caf_lut_model.sv
`timescale 1ns/1ps
// ============================================================
// Table responder; delay 0 answers two cycles after the request
module caf_lut_model (
    input wire clock,
    input wire sys_rst,
    input wire lut_search_req,
    input wire [3:0] dly,
    input wire hit,
    output logic lut_result_valid,
    output logic lut_id_match
);
    logic pend_r;
    logic [3:0] cnt_r;
    wire fire = pend_r && cnt_r == 4'h0;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pend_r <= 1'b0;
            cnt_r <= 4'h0;
            lut_result_valid <= 1'b0;
            lut_id_match <= 1'b0;
        end else begin
            lut_result_valid <= fire;
            // Toggles outside results so a stale match is never mistaken for one
            lut_id_match <= fire ? hit : ~lut_id_match;
            pend_r <= lut_search_req || (pend_r && !fire);
            cnt_r <= lut_search_req ? dly : cnt_r - {3'h0, cnt_r != 4'h0};
        end
    end
endmodule

//--- sim/caf_mode_sva.sv
`timescale 1ns/1ps
`include "caf_defs.vh"
// ============================================================
// Port checker
module caf_mode_sva (
    input wire clock,
    input wire sys_rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire rx_eval_start,
    input wire rx_ctrl_enabled,
    input wire lut_result_valid,
    input wire lut_id_match,
    input wire lut_search_req,
    input wire rx_accept,
    input wire rx_discard,
    input wire rx_auto_store,
    input wire auto_store_extension_enable,
    input wire filter_bypass,
    input wire filter_off,
    input wire [`CAF_SECT_W-1:0] lut_section_start
);
    wire [2:0] mode = {auto_store_extension_enable, filter_bypass, filter_off};
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_addr(logic [31:0] a, logic w);
        hsel && hready && htrans[1] && haddr == a && hwrite == w;
    endsequence
    a_reset_mode: assert property (disable iff (1'b0)
        sys_rst |-> mode == `CAF_MODE_RST) else $error("mode not at reset value");
    a_read_zero: assert property (s_addr(`CAF_MODE_ADDR, 1'b0) |=>
        hrdata == {29'h00000000, $past(mode)}) else $error("mode read wrong");
    a_mode_write: assert property (s_addr(`CAF_MODE_ADDR, 1'b1) ##1 1'b1 |=>
        mode == $past(hwdata[2:0])) else $error("mode write lost");
    a_sect_write: assert property (s_addr(`CAF_SECT_ADDR, 1'b1) ##1
        (filter_bypass || filter_off) |=> lut_section_start == $past(hwdata[11:2]))
        else $error("section write lost");
    a_sect_lock: assert property (s_addr(`CAF_SECT_ADDR, 1'b1) ##1
        (!filter_bypass && !filter_off) |=> $stable(lut_section_start))
        else $error("section written while screening");
    a_bypass_pass: assert property (rx_eval_start && filter_bypass |=>
        rx_accept == $past(rx_ctrl_enabled) && rx_discard != $past(rx_ctrl_enabled)
        && !lut_search_req) else $error("bypass frame wrong");
    a_off_drop: assert property (rx_eval_start && !filter_bypass && filter_off |=>
        rx_discard && !rx_accept && !lut_search_req) else $error("off frame kept");
    a_norm_search: assert property (rx_eval_start && mode[1:0] == 2'h0 && rx_ctrl_enabled
        |=> lut_search_req && !rx_accept && !rx_discard) else $error("no table search");
    a_norm_result: assert property (lut_result_valid && rx_ctrl_enabled |=>
        rx_accept == $past(lut_id_match) && rx_discard != $past(lut_id_match))
        else $error("search result ignored");
    a_bus_okay: assert property (hreadyout && hresp == `CAF_HRESP_OKAY)
        else $error("bus not ready or not okay");
    a_store_accept: assert property (rx_auto_store |->
        rx_accept && $past(lut_result_valid)) else $error("stray auto store");
endmodule
bind caf_mode_top caf_mode_sva caf_mode_sva_i (.*);

//--- sim/can_acceptance_filter_mode_tb.sv
`timescale 1ns/1ps
`include "caf_defs.vh"
// ============================================================
// Bench top
module can_acceptance_filter_mode_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rx_eval_start = 1'b0;
    logic rx_ctrl_enabled = 1'b0;
    logic hit = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [3:0] dly = 4'h0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [31:0] rd;
    logic [31:0] r;
    wire hreadyout, lut_search_req, lut_result_valid, lut_id_match;
    wire rx_accept, rx_discard, rx_auto_store;
    wire [31:0] hrdata;
    int failures = 0;
    int checks_done = 0;
    int mode_m = 1;
    int sect_m = 0;
    always #5 clock = ~clock;
    caf_mode_top caf_mode_top_i (.*, .hready(hreadyout), .hresp(),
        .auto_store_extension_enable(), .filter_bypass(), .filter_off(), .lut_section_start());
    caf_lut_model caf_lut_model_i (.*);
    // ============================================================
    // Tasks
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= `CAF_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= `CAF_HSIZE_WORD;
        haddr <= a;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic frame(input logic en, input logic h, input logic [3:0] d);
        logic [2:0] e;
        // Mode is judged as it stands when evaluation starts
        e = 3'h2;
        if (en && mode_m[1]) e = 3'h4;
        else if (en && !mode_m[0]) e = {h, !h, h && mode_m[2]};
        rx_ctrl_enabled <= en;
        hit <= h;
        dly <= d;
        rx_eval_start <= 1'b1;
        @(posedge clock);
        rx_eval_start <= 1'b0;
        repeat (20) begin
            @(posedge clock);
            if ((rx_accept || rx_discard) === 1'b1) break;
        end
        cmp("frame", {29'h0, e}, {29'h0, rx_accept, rx_discard, rx_auto_store});
    endtask
    task automatic test_done;
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ============================================================
    // Sequence
    initial begin
        r = $urandom(25354);
        sys_rst <= 1'b1;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        bus(1'b0, `CAF_MODE_ADDR, 0);
        cmp("mode", 32'h00000001, rd);
        bus(1'b0, `CAF_SECT_ADDR, 0);
        cmp("sect", 32'h00000000, rd);
        bus(1'b0, 32'hE0087008, 0);
        cmp("unmapped", 32'h00000000, rd);
        frame(1'b1, 1'b1, 4'h0);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            bus(1'b1, `CAF_MODE_ADDR, {r[31:3], i[2:0]});
            mode_m = i;
            bus(1'b0, `CAF_MODE_ADDR, 0);
            cmp("mode", mode_m, rd);
            r = $urandom;
            bus(1'b1, `CAF_SECT_ADDR, r);
            if (i[1:0] != 0) sect_m = r[11:2];
            bus(1'b0, `CAF_SECT_ADDR, 0);
            cmp("sect", sect_m << 2, rd);
            frame(1'b1, r[0], r[4:1]);
            frame(1'b1, !r[0], 4'h0);
            frame(1'b0, r[1], 4'h0);
        end
        bus(1'b1, `CAF_MODE_ADDR, 32'h00000004);
        mode_m = 4;
        fork
            frame(1'b1, 1'b1, 4'h6);
            begin
                repeat (2) @(posedge clock);
                bus(1'b1, `CAF_MODE_ADDR, 32'h00000001);
                mode_m = 1;
            end
        join
        bus(1'b0, `CAF_STAT_ADDR, 0);
        cmp("stat", 32'h00000004 << `CAF_STAT_MODE_LSB, rd);
        frame(1'b1, 1'b1, 4'h0);
        bus(1'b1, `CAF_MODE_ADDR, 32'h00000006);
        // Reset in mid-run must bring back the reset values
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        mode_m = 1;
        sect_m = 0;
        bus(1'b0, `CAF_MODE_ADDR, 0);
        cmp("mode", mode_m, rd);
        bus(1'b0, `CAF_SECT_ADDR, 0);
        cmp("sect", sect_m << 2, rd);
        bus(1'b0, `CAF_STAT_ADDR, 0);
        cmp("stat", mode_m << `CAF_STAT_MODE_LSB, rd);
        frame(1'b1, 1'b1, 4'h0);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        test_done;
    end
endmodule
